// file: rtl/lpr_pkg.sv
// Constants for the LCD pin role and phase map register bank.
// Assumes a byte-wide register port and a 40 MHz system clock.
`default_nettype none

package lpr_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 64;
    localparam int NUM_BANKS = 8;
    localparam int NUM_PHASES = 8;
    localparam int CLK_PERIOD_NS = 25;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] PEN_BASE = 8'h00;  // 8 enable banks
    localparam logic [7:0] ROLE_BASE = 8'h08; // 8 role banks
    localparam logic [7:0] CTRL_ADDR = 8'h10;
    localparam logic [7:0] STAT_ADDR = 8'h11;
    localparam logic [7:0] WF_BASE = 8'h40;   // 64 phase map bytes

    // ************************************************************
    // Fields and values after reset
    // ************************************************************
    localparam int CTRL_EN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Phase index as seen in a phase map byte
    typedef enum logic [2:0] {
        LPR_PH_A = 3'h0,
        LPR_PH_B = 3'h1,
        LPR_PH_C = 3'h2,
        LPR_PH_D = 3'h3,
        LPR_PH_E = 3'h4,
        LPR_PH_F = 3'h5,
        LPR_PH_G = 3'h6,
        LPR_PH_H = 3'h7
    } lpr_phase_t;

endpackage

`default_nettype wire

// file: rtl/lpr_pin_map.sv
// Register bank that gives each LCD pin its role and its phase map byte.
// Assumes an external sequencer supplies the current phase and that
// the host only issues single-byte accesses on the register port.
//
// Notes on behaviour
// - enabled pin drives backplane when role bit is 1, frontplane when 0.
// - with global drive enable clear, role bits affect no pin.
// - 64 role bits in eight byte banks; bit n of bank k is pin 8k+n.
// - reset leaves role and phase map contents untouched; software initialises.
// - role and phase map contents survive stop2 unchanged.
// - frontplane pin uses phase map byte as segment state, bit 7 is H.
// - backplane pin is active only in phases set in its byte.
// - only pins with their pin enable bit set take part in LCD driving.
//
// Local design decisions: the register addresses and strobed register access.
`default_nettype none

module lpr_pin_map #(
    parameter int NUM_PINS = lpr_pkg::NUM_PINS,
    parameter int CHK_PIN = 9
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [lpr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lpr_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [lpr_pkg::DATA_W-1:0] o_rdata,
    // Low power and sequencer
    input wire logic i_stop2,
    input wire logic [2:0] i_phase,
    // Pin drive
    output logic [NUM_PINS-1:0] o_lcd_active,
    output logic [NUM_PINS-1:0] o_lcd_bp,
    output logic [NUM_PINS-1:0] o_lcd_level
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Byte k of a 64-bit bank vector
    function automatic logic [7:0] f_byte(input logic [63:0] vec, input logic [2:0] k);
        f_byte = vec[{k, 3'h0} +: 8];
    endfunction

    // Population count of a 64-bit vector
    function automatic logic [6:0] f_count(input logic [63:0] vec);
        logic [6:0] n;
        n = 7'h00;
        for (int i = 0; i < 64; i++) begin
            n = n + {6'h00, vec[i]};
        end
        f_count = n;
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    logic [63:0] pen_reg;
    logic [63:0] role_reg;
    logic [7:0] wf_mem [0:63];
    logic [7:0] ctrl_reg;
    logic [6:0] bp_count;
    logic [63:0] drive;
    logic [63:0] lvl_next;
    logic [7:0] rd_mux;
    logic wr_ok;
    logic sel_pen;
    logic sel_role;
    logic sel_wf;
    logic ctrl_en;

    // Decode; writes are gated off by i_stop2, so none land in stop2
    assign wr_ok = i_wr && !i_stop2;
    assign sel_pen = (i_addr[7:3] == lpr_pkg::PEN_BASE[7:3]);
    assign sel_role = (i_addr[7:3] == lpr_pkg::ROLE_BASE[7:3]);
    assign sel_wf = (i_addr[7:6] == lpr_pkg::WF_BASE[7:6]);
    assign ctrl_en = ctrl_reg[lpr_pkg::CTRL_EN_BIT];

    // ************************************************************
    // Register writes
    // ************************************************************

    // Pin enable banks, no reset on purpose
    always_ff @(posedge i_ref_clk) begin
        if (wr_ok && sel_pen) begin
            pen_reg[{i_addr[2:0], 3'h0} +: 8] <= i_wdata;
        end
    end

    // Role banks; bit n of bank k lands on pin 8k+n
    always_ff @(posedge i_ref_clk) begin
        if (wr_ok && sel_role) begin
            role_reg[{i_addr[2:0], 3'h0} +: 8] <= i_wdata;
        end
    end

    // Phase map bytes; left undefined after reset, kept through stop2
    always_ff @(posedge i_ref_clk) begin
        if (wr_ok && sel_wf) begin
            wf_mem[i_addr[5:0]] <= i_wdata;
        end
    end

    // Control register holds the global drive enable
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            ctrl_reg <= lpr_pkg::CTRL_RESET;
        end else if (wr_ok && i_addr == lpr_pkg::CTRL_ADDR) begin
            ctrl_reg <= {7'h00, i_wdata[lpr_pkg::CTRL_EN_BIT]};
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************

    // Global enable gates every pin enable; role bits only matter behind it
    assign drive = ctrl_en ? pen_reg : 64'h0000_0000_0000_0000;

    // Same bit pick serves segment state and backplane activity
    always_comb begin
        lvl_next = 64'h0000_0000_0000_0000;
        for (int p = 0; p < 64; p++) begin
            lvl_next[p] = drive[p] & wf_mem[p][i_phase];
        end
    end

    // Registered pin outputs; held while in stop2
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_lcd_active <= '0;
            o_lcd_bp <= '0;
            o_lcd_level <= '0;
        end else if (!i_stop2) begin
            o_lcd_active <= drive[NUM_PINS-1:0];
            o_lcd_bp <= drive[NUM_PINS-1:0] & role_reg[NUM_PINS-1:0];
            o_lcd_level <= lvl_next[NUM_PINS-1:0];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************

    // Backplane count of live pins, a cheap sanity check for software
    assign bp_count = f_count(drive & role_reg);

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = lpr_pkg::RDATA_IDLE;
        if (sel_pen) begin
            rd_mux = f_byte(pen_reg, i_addr[2:0]);
        end else if (sel_role) begin
            rd_mux = f_byte(role_reg, i_addr[2:0]);
        end else if (sel_wf) begin
            rd_mux = wf_mem[i_addr[5:0]];
        end else if (i_addr == lpr_pkg::CTRL_ADDR) begin
            rd_mux = ctrl_reg;
        end else if (i_addr == lpr_pkg::STAT_ADDR) begin
            rd_mux = {1'b0, bp_count};
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata <= lpr_pkg::RDATA_IDLE;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= lpr_pkg::RDATA_IDLE;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    // Backplane output follows role bit of live pins
    property p_bp_role;
        !i_stop2 |=> (o_lcd_bp == ($past(role_reg[NUM_PINS-1:0]) & o_lcd_active));
    endproperty
    a_bp_role: assert property (p_bp_role)
        else $error("backplane output disagrees with role bit");

    // Global enable off leaves every pin idle
    property p_global_off;
        !ctrl_en && !i_stop2 |=> (o_lcd_active == '0) && (o_lcd_level == '0) && (o_lcd_bp == '0);
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("pin driven while global enable is clear");

    // Role byte write lands in the addressed bank
    property p_role_write;
        wr_ok && sel_role |=> f_byte(role_reg, $past(i_addr[2:0])) == $past(i_wdata);
    endproperty
    a_role_write: assert property (p_role_write)
        else $error("role bank write not stored at its bank");

    // Reset leaves role contents alone
    property p_reset_keeps;
        disable iff (1'b0) i_reset && !wr_ok |=> $stable(role_reg);
    endproperty
    a_reset_keeps: assert property (p_reset_keeps)
        else $error("reset altered role contents");

    // Stop2 freezes role and enable contents and the level output
    property p_stop2_keeps;
        disable iff (1'b0) i_stop2 |=> $stable(role_reg) && $stable(pen_reg) &&
            $stable(o_lcd_level);
    endproperty
    a_stop2_keeps: assert property (p_stop2_keeps)
        else $error("state changed during stop2");

    // Frontplane segment state comes from its phase map bit
    property p_fp_level;
        !i_stop2 && ctrl_en && pen_reg[CHK_PIN] && !role_reg[CHK_PIN] |=>
            !o_lcd_bp[CHK_PIN] && (o_lcd_level[CHK_PIN] == $past(wf_mem[CHK_PIN][i_phase]));
    endproperty
    a_fp_level: assert property (p_fp_level)
        else $error("frontplane segment state wrong");

    // Backplane active only in selected phases
    property p_bp_level;
        !i_stop2 && ctrl_en && pen_reg[CHK_PIN] && role_reg[CHK_PIN] |=>
            o_lcd_bp[CHK_PIN] && (o_lcd_level[CHK_PIN] == $past(wf_mem[CHK_PIN][i_phase]));
    endproperty
    a_bp_level: assert property (p_bp_level)
        else $error("backplane phase activity wrong");

    // Cleared pin enable keeps the pin out of LCD driving
    property p_pen_off;
        !i_stop2 && !pen_reg[CHK_PIN] |=> !o_lcd_active[CHK_PIN] && !o_lcd_level[CHK_PIN];
    endproperty
    a_pen_off: assert property (p_pen_off)
        else $error("disabled pin took part in LCD driving");

    // Phase map stays readable with drive off, for one cycle only
    property p_read_back;
        i_rd && !ctrl_en && sel_wf |=> (o_rdata == $past(wf_mem[i_addr[5:0]])) ##1
            (!$past(i_rd) -> o_rdata == lpr_pkg::RDATA_IDLE);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("phase map read back wrong while disabled");

    // Read data falls back to idle after a cycle without read
    property p_rdata_idle;
        !i_rd |=> o_rdata == lpr_pkg::RDATA_IDLE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle after a cycle without read");

    // A pin is live only with its own enable and the global enable
    property p_active_follows;
        !i_stop2 |=> o_lcd_active ==
            ($past(pen_reg[NUM_PINS-1:0]) & {NUM_PINS{$past(ctrl_en)}});
    endproperty
    a_active_follows: assert property (p_active_follows)
        else $error("pin activity disagrees with its enables");

    // Pin enable byte write lands in the addressed bank
    property p_pen_write;
        wr_ok && sel_pen |=> f_byte(pen_reg, $past(i_addr[2:0])) == $past(i_wdata);
    endproperty
    a_pen_write: assert property (p_pen_write)
        else $error("pin enable write not stored at its bank");

    // Phase map byte write lands at the addressed pin
    property p_wf_write;
        wr_ok && sel_wf |=> wf_mem[$past(i_addr[5:0])] == $past(i_wdata);
    endproperty
    a_wf_write: assert property (p_wf_write)
        else $error("phase map write not stored at its pin");

    // Control write sets the global drive enable
    property p_ctrl_write;
        wr_ok && (i_addr == lpr_pkg::CTRL_ADDR) |=>
            ctrl_en == $past(i_wdata[lpr_pkg::CTRL_EN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("global drive enable not taken from write");

    // Stop2 holds the active and backplane outputs and the control state
    property p_stop2_outputs;
        i_stop2 |=> $stable(o_lcd_active) && $stable(o_lcd_bp) && $stable(ctrl_reg);
    endproperty
    a_stop2_outputs: assert property (p_stop2_outputs)
        else $error("pin output or control moved during stop2");

    // Role bank read returns the addressed byte
    property p_rd_role;
        i_rd && sel_role |=> o_rdata == f_byte($past(role_reg), $past(i_addr[2:0]));
    endproperty
    a_rd_role: assert property (p_rd_role)
        else $error("role bank read returned wrong byte");

    // Pin enable bank read returns the addressed byte
    property p_rd_pen;
        i_rd && sel_pen |=> o_rdata == f_byte($past(pen_reg), $past(i_addr[2:0]));
    endproperty
    a_rd_pen: assert property (p_rd_pen)
        else $error("pin enable read returned wrong byte");

    // Unmapped offsets read as idle, so software never sees stale data
    property p_unmapped_read;
        i_rd && !sel_pen && !sel_role && !sel_wf && (i_addr != lpr_pkg::CTRL_ADDR) &&
            (i_addr != lpr_pkg::STAT_ADDR) |=> o_rdata == lpr_pkg::RDATA_IDLE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned data");

    // No phase level on a pin outside LCD driving
    property p_level_needs_active;
        (o_lcd_level & ~o_lcd_active) == '0;
    endproperty
    a_level_needs_active: assert property (p_level_needs_active)
        else $error("phase level on a pin that is not live");

    // Backplane role shows only on live pins
    property p_bp_needs_active;
        (o_lcd_bp & ~o_lcd_active) == '0;
    endproperty
    a_bp_needs_active: assert property (p_bp_needs_active)
        else $error("backplane shown on a pin that is not live");

    // Spare control bits always read zero
    property p_ctrl_reserved;
        ctrl_reg[7:1] == 7'h00;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("spare control bits set");

    // Main scenarios
    c_bp_pin: cover property (ctrl_en && o_lcd_bp[CHK_PIN] && o_lcd_level[CHK_PIN]);
    c_fp_pin: cover property (ctrl_en && o_lcd_active[CHK_PIN] && !o_lcd_bp[CHK_PIN]);
    c_stop2: cover property (i_stop2 ##1 !i_stop2);
    c_rd_role: cover property (i_rd && sel_role ##1 i_rd && sel_wf);
    c_wr_stop2: cover property (i_wr && i_stop2);

endmodule

`default_nettype wire

// file: test/lpr_glass_model.sv
// Behavioural model of the segment glass hung on the pin drive outputs.
// Assumes one bit per pin and that the pin drive outputs settle between edges.
`default_nettype none

module lpr_glass_model (
    // Pin drive seen at the glass
    input wire logic [63:0] i_lcd_active,
    input wire logic [63:0] i_lcd_bp,
    input wire logic [63:0] i_lcd_level,
    // Segments that see a voltage across them
    output logic [63:0] o_seg_on
);
    // Any backplane pulled active in this phase
    logic bp_on;
    assign bp_on = |(i_lcd_active & i_lcd_bp & i_lcd_level);
    // Segment lights only opposite an active backplane, so a stray level stays dark
    assign o_seg_on = i_lcd_active & ~i_lcd_bp & i_lcd_level & {64{bp_on}};
endmodule

`default_nettype wire

// file: test/lpr_pin_map_tb_top.sv
// Self-checking bench for the pin role and phase map register bank.
// Assumes a byte-wide register port and the glass model on the pin outputs.
`default_nettype none

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module lpr_pin_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] WF9 = 8'h81;
    localparam logic [7:0] WF10 = 8'hA5;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_stop2 = 1'b0;
    logic [2:0] i_phase = 3'h0;
    logic [7:0] o_rdata;
    logic [63:0] act;
    logic [63:0] bp;
    logic [63:0] lvl;
    logic [63:0] seg;
    int fail_count = 0;
    int checks = 0;
    int k;

    // ************************************************************
    // Clock, design and glass
    // ************************************************************
    always #12.5 i_ref_clk = ~i_ref_clk;
    lpr_pin_map i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stop2(i_stop2),
        .i_phase(i_phase), .o_lcd_active(act), .o_lcd_bp(bp), .o_lcd_level(lvl));
    lpr_glass_model i_glass (.i_lcd_active(act), .i_lcd_bp(bp), .i_lcd_level(lvl),
        .o_seg_on(seg));

    // ************************************************************
    // Access tasks
    // ************************************************************
    // Single byte write, the only width the host ever uses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 `CHK(nm, e, o_rdata)
    endtask
    // Pin outputs follow the phase one edge later
    task automatic ph(input logic [2:0] p);
        @(posedge i_ref_clk);
        i_phase <= p;
        @(posedge i_ref_clk);
        #1;
    endtask
    // Distinct byte per role bank; bank 1 makes pins 9 and 11 backplanes
    function automatic logic [7:0] role_byte(input int b);
        return (b == 1) ? 8'h0A : 8'(8'h30 + b);
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    // Watchdog far beyond the 150 or so cycles the tests need
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1 `CHK("active after reset", 64'h0, act)
        // Distinct byte per role bank catches swapped banks
        // Every enable bank known before drive is on; pin 9 starts disabled
        for (k = 0; k < 8; k++) wr(8'(lpr_pkg::PEN_BASE + k), 8'h00);
        for (k = 0; k < 8; k++) wr(8'(lpr_pkg::ROLE_BASE + k), role_byte(k));
        for (k = 0; k < 8; k++) rdc(8'(lpr_pkg::ROLE_BASE + k), role_byte(k), "role");
        rdc(8'h20, 8'h00, "unmapped");
        @(posedge i_ref_clk);
        #1 `CHK("rdata idle", 8'h00, o_rdata)
        $display("test role banks done");
        // Pin 9 backplane, pin 10 frontplane, pin 11 role set but not enabled
        wr(8'(lpr_pkg::PEN_BASE + 1), 8'h06);
        rdc(8'(lpr_pkg::PEN_BASE + 1), 8'h06, "pin enable bank");
        wr(8'(lpr_pkg::WF_BASE + 9), WF9);
        wr(8'(lpr_pkg::WF_BASE + 10), WF10);
        ph(3'h0);
        `CHK("active global off", 64'h0, act)
        rdc(lpr_pkg::STAT_ADDR, 8'h00, "status off");
        wr(lpr_pkg::CTRL_ADDR, 8'h01); // roles written before global enable
        rdc(lpr_pkg::STAT_ADDR, 8'h01, "status on");
        for (k = 0; k < 8; k++) begin
            ph(3'(k));
            `CHK("active 11..9", 3'b011, act[11:9])
            `CHK("bp 10..9", 2'b01, bp[10:9])
            `CHK("level pin 9", WF9[k], lvl[9])
            `CHK("level pin 10", WF10[k], lvl[10])
            `CHK("segment pin 10", WF9[k] & WF10[k], seg[10])
        end
        $display("test pin drive done");
        // Stop2 freezes pins, blocks writes, keeps contents
        @(posedge i_ref_clk) i_stop2 <= 1'b1;
        wr(8'(lpr_pkg::ROLE_BASE + 1), 8'h00);
        ph(3'h1);
        `CHK("frozen level", 1'b1, lvl[9])
        rdc(8'(lpr_pkg::ROLE_BASE + 1), 8'h0A, "role in stop2");
        @(posedge i_ref_clk) i_stop2 <= 1'b0;
        ph(3'h1);
        `CHK("level after wake", 1'b0, lvl[9])
        `CHK("bp after wake", 1'b1, bp[9])
        $display("test stop2 done");
        // Reset in mid-run leaves role and phase map bytes alone
        @(posedge i_ref_clk) i_reset <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rdc(lpr_pkg::CTRL_ADDR, lpr_pkg::CTRL_RESET, "control");
        rdc(8'(lpr_pkg::ROLE_BASE + 1), 8'h0A, "role kept");
        rdc(8'(lpr_pkg::WF_BASE + 9), WF9, "phase map kept");
        ph(3'h0);
        `CHK("active after reset", 64'h0, act)
        wr(lpr_pkg::CTRL_ADDR, 8'hFF);
        rdc(lpr_pkg::CTRL_ADDR, 8'h01, "control spare bits");
        ph(3'h0);
        `CHK("drive without rewrite", 1'b1, bp[9] & lvl[9])
        $display("test second reset done");
        // Swap pins 9 and 10 so pin 9 is also seen as a frontplane
        wr(8'(lpr_pkg::ROLE_BASE + 1), 8'h04);
        rdc(lpr_pkg::STAT_ADDR, 8'h01, "status swapped");
        for (k = 0; k < 8; k++) begin
            ph(3'(k));
            `CHK("bp 10..9 swapped", 2'b10, bp[10:9])
            `CHK("level pin 9 front", WF9[k], lvl[9])
            `CHK("segment pin 9", WF9[k] & WF10[k], seg[9])
        end
        $display("test role swap done");
        give_verdict;
    end
endmodule

`default_nettype wire
